/* File: hw/bus_config_register_pair.sv */
// Volatile and non-volatile bus configuration registers with lock and burst logic
`timescale 1ns/10ps
`default_nettype none
`include "bus_config_map.svh"
module bus_config_register_pair
#(
    parameter int ADDR_W = 24
)
(
    // Clock and resets
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic FACTORY_RST_I,
    // Configuration commands
    input wire logic LOAD_VOLATILE_I,
    input wire logic PROGRAM_NONVOLATILE_I,
    input wire logic ERASE_NONVOLATILE_I,
    input wire logic [15:0] CONFIG_DATA_I,
    input wire logic SW_RESET_I,
    output logic CMD_REFUSED_O,
    // Register readback
    output logic [15:0] VOLATILE_BUS_CONFIG_O,
    output logic [15:0] NONVOLATILE_BUS_CONFIG_O,
    output logic VOLATILE_SELECTED_O,
    // Lock states
    output logic NV_ALTERABLE_O,
    output logic V_ALTERABLE_O,
    output logic PERMANENT_LOCK_O,
    // Secure region
    input wire logic SECURE_PROG_REQ_I,
    output logic SECURE_PROG_ALLOW_O,
    // Active bus characteristics
    output logic [2:0] DRIVE_STRENGTH_O,
    output logic [1:0] SECTOR_MAP_O,
    output logic [4:0] READ_LATENCY_O,
    output logic LATENCY_SUPPORTED_O,
    output logic [1:0] BURST_LENGTH_O,
    // Burst sequencing
    input wire logic BURST_START_I,
    input wire logic [ADDR_W-1:0] BURST_START_ADDR_I,
    input wire logic BURST_TYPE_BIT_I,
    input wire logic BURST_NEXT_I,
    output logic [ADDR_W-1:0] BURST_ADDR_O
);

    // ------------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------------
    generate
        if (ADDR_W < 6)
        begin : g_bad_width
            $error("ADDR_W must cover a 64-byte wrap group");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    bus_config_pkg::ctl_state_t state;
    logic [15:0] nonvolatile_bus_config;
    logic [15:0] volatile_bus_config;
    logic [15:0] nv_snapshot;
    logic [15:0] active_config;
    logic [15:0] next_program;
    logic [15:0] next_load;
    logic volatile_written;
    logic volatile_selected;
    logic nv_alterable;
    logic v_alterable;
    logic permanent_lock;
    logic run;
    logic load_ok;
    logic program_ok;
    logic erase_ok;
    logic nv_change;
    logic [4:0] next_latency;
    logic next_supported;

    assign run = (state == bus_config_pkg::ST_RUN);

    assign next_load = (CONFIG_DATA_I & ~`RSVD_FORCE_MASK) | `RSVD_FORCE_VALUE;
    // Flash cells only clear on program; erase sets them
    assign next_program = ((nonvolatile_bus_config & CONFIG_DATA_I) & ~`RSVD_FORCE_MASK) | `RSVD_FORCE_VALUE;

    // ------------------------------------------------------------------------
    // Lock decode
    // ------------------------------------------------------------------------
    // locks from both freeze bits
    config_lock_decode u_lock
    (
        .nv_freeze_i(nonvolatile_bus_config[`FLD_CFG_FREEZE]),
        .v_freeze_i(volatile_bus_config[`FLD_CFG_FREEZE]),
        .nv_alterable_o(nv_alterable),
        .v_alterable_o(v_alterable),
        .permanent_o(permanent_lock)
    );

    assign load_ok = run && LOAD_VOLATILE_I && v_alterable;
    assign program_ok = run && PROGRAM_NONVOLATILE_I && nv_alterable;
    assign erase_ok = run && ERASE_NONVOLATILE_I && !PROGRAM_NONVOLATILE_I && nv_alterable;
    assign nv_change = program_ok || erase_ok;

    // ------------------------------------------------------------------------
    // Start-up sequence
    // ------------------------------------------------------------------------
    // One cycle after release copies the stored setting before any command
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state <= bus_config_pkg::ST_INIT;
        end
        else
        begin
            case (state)
                bus_config_pkg::ST_INIT: state <= bus_config_pkg::ST_RUN;
                bus_config_pkg::ST_RUN: state <= bus_config_pkg::ST_RUN;
                default: state <= bus_config_pkg::ST_INIT;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Non-volatile register
    // ------------------------------------------------------------------------
    // Survives hardware reset; only the factory reset restores it
    always_ff @(posedge REF_CLK_I or posedge FACTORY_RST_I)
    begin
        if (FACTORY_RST_I)
        begin
            nonvolatile_bus_config <= `CFG_FACTORY_VALUE;
        end
        else if (program_ok)
        begin
            nonvolatile_bus_config <= next_program;
        end
        else if (erase_ok)
        begin
            nonvolatile_bus_config <= `CFG_ERASED_VALUE;
        end
    end

    // stored setting acts only from reset
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            nv_snapshot <= `CFG_FACTORY_VALUE;
        end
        else if (!run)
        begin
            nv_snapshot <= nonvolatile_bus_config;
        end
    end

    // ------------------------------------------------------------------------
    // Volatile register
    // ------------------------------------------------------------------------
    // freeze bits follow the stored value at reset
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            volatile_bus_config <= `CFG_FACTORY_VALUE;
        end
        else if (!run)
        begin
            volatile_bus_config <= nonvolatile_bus_config;
        end
        else if (load_ok)
        begin
            volatile_bus_config <= next_load;
        end
        else if (program_ok && !volatile_written)
        begin
            volatile_bus_config <= next_program;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            volatile_written <= 1'b0;
        end
        else if (load_ok || program_ok)
        begin
            volatile_written <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            volatile_selected <= 1'b0;
        end
        else if (load_ok)
        begin
            volatile_selected <= 1'b1;
        end
    end

    assign active_config = volatile_selected ? volatile_bus_config : nv_snapshot;

    // ------------------------------------------------------------------------
    // Latency decode
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_latency = `LAT_NONE_CLOCKS;
        next_supported = 1'b0;
        // codes 0 to A count up from five clocks, code B gives 16, codes C to F unsupported
        if (active_config[`FLD_LAT_HI:`FLD_LAT_LO] <= `LAT_CODE_SEQ_MAX)
        begin
            next_latency = `LAT_BASE_CLOCKS + {1'b0, active_config[`FLD_LAT_HI:`FLD_LAT_LO]};
            next_supported = 1'b1;
        end
        else if (active_config[`FLD_LAT_HI:`FLD_LAT_LO] == `LAT_CODE_TOP)
        begin
            next_latency = `LAT_TOP_CLOCKS;
            next_supported = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            DRIVE_STRENGTH_O <= 3'h0;
            SECTOR_MAP_O <= 2'h2;
            READ_LATENCY_O <= `LAT_TOP_CLOCKS;
            LATENCY_SUPPORTED_O <= 1'b1;
            BURST_LENGTH_O <= 2'h3;
            SECURE_PROG_ALLOW_O <= 1'b0;
        end
        else
        begin
            DRIVE_STRENGTH_O <= active_config[`FLD_DRIVE_HI:`FLD_DRIVE_LO];
            SECTOR_MAP_O <= active_config[`FLD_MAP_HI:`FLD_MAP_LO];
            READ_LATENCY_O <= next_latency;
            LATENCY_SUPPORTED_O <= next_supported;
            BURST_LENGTH_O <= active_config[`FLD_BURST_HI:`FLD_BURST_LO];
            SECURE_PROG_ALLOW_O <= run && SECURE_PROG_REQ_I && active_config[`FLD_SECURE_FREEZE];
        end
    end

    // Refusal is a one-cycle pulse after the rejected command
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            CMD_REFUSED_O <= 1'b0;
        end
        else
        begin
            CMD_REFUSED_O <= (LOAD_VOLATILE_I && !load_ok)
                || (PROGRAM_NONVOLATILE_I && !program_ok)
                || (ERASE_NONVOLATILE_I && !PROGRAM_NONVOLATILE_I && !erase_ok);
        end
    end

    assign VOLATILE_BUS_CONFIG_O = volatile_bus_config;
    assign NONVOLATILE_BUS_CONFIG_O = nonvolatile_bus_config;
    assign VOLATILE_SELECTED_O = volatile_selected;
    assign NV_ALTERABLE_O = nv_alterable && run;
    assign V_ALTERABLE_O = v_alterable && run;
    assign PERMANENT_LOCK_O = permanent_lock;

    // ------------------------------------------------------------------------
    // Burst sequencing
    // ------------------------------------------------------------------------
    // Reserved length code falls back to linear counting
    burst_address_gen #(.ADDR_W(ADDR_W)) u_burst
    (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .start_i(BURST_START_I),
        .start_addr_i(BURST_START_ADDR_I),
        .linear_i(BURST_TYPE_BIT_I),
        .len_i(bus_config_pkg::burst_len_t'(active_config[`FLD_BURST_HI:`FLD_BURST_LO])),
        .next_i(BURST_NEXT_I),
        .addr_o(BURST_ADDR_O)
    );

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_zero_load;
        load_ok && (CONFIG_DATA_I[`FLD_LAT_HI:`FLD_LAT_LO] == 4'h0);
    endsequence

    sequence s_quiet;
        !LOAD_VOLATILE_I && !PROGRAM_NONVOLATILE_I && !ERASE_NONVOLATILE_I;
    endsequence

    init_one_cycle_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        !run |=> run)
        else $error("start-up copy did not finish in one cycle");

    frozen_load_refused_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (run && LOAD_VOLATILE_I && !volatile_bus_config[`FLD_CFG_FREEZE]) |=>
        ($stable(volatile_bus_config) && CMD_REFUSED_O))
        else $error("frozen volatile register changed");

    frozen_nv_refused_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I || FACTORY_RST_I)
        (run && (PROGRAM_NONVOLATILE_I || ERASE_NONVOLATILE_I) && !nv_alterable) |=>
        $stable(nonvolatile_bus_config))
        else $error("locked nonvolatile register changed");

    loaded_kept_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (nv_change && volatile_written && !LOAD_VOLATILE_I) |=> $stable(volatile_bus_config))
        else $error("nonvolatile change disturbed loaded value");

    unloaded_copy_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I || FACTORY_RST_I)
        (program_ok && !volatile_written && !LOAD_VOLATILE_I) |=>
        (volatile_bus_config == nonvolatile_bus_config))
        else $error("first program did not copy into volatile");

    snapshot_hold_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        run |=> $stable(nv_snapshot))
        else $error("stored setting acted before reset");

    selector_kept_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (SW_RESET_I && !load_ok) |=> $stable(volatile_selected))
        else $error("software reset moved selector");

    load_selects_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        load_ok |=> (volatile_selected && (active_config == volatile_bus_config)))
        else $error("load did not hand over to volatile");

    latency_five_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        s_zero_load ##1 s_quiet |=> (READ_LATENCY_O == 5'h05) && LATENCY_SUPPORTED_O)
        else $error("code zero did not give five clocks");

    secure_block_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        !active_config[`FLD_SECURE_FREEZE] |=> !SECURE_PROG_ALLOW_O)
        else $error("secure region program allowed while frozen");

endmodule // bus_config_register_pair
`default_nettype wire

/* File: pkg/bus_config_map.svh */
// Field positions, reset values and timing counts of the bus configuration pair
`ifndef BUS_CONFIG_MAP_SVH
`define BUS_CONFIG_MAP_SVH

// ----------------------------------------------------------------------------
// Field layout, shared by both registers
// ----------------------------------------------------------------------------
`define CFG_WIDTH 16
`define FLD_DRIVE_HI 14
`define FLD_DRIVE_LO 12
`define FLD_CFG_FREEZE 11
`define FLD_SECURE_FREEZE 10
`define FLD_MAP_HI 9
`define FLD_MAP_LO 8
`define FLD_LAT_HI 7
`define FLD_LAT_LO 4
`define FLD_BURST_HI 1
`define FLD_BURST_LO 0

// ----------------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------------
`define CFG_FACTORY_VALUE 16'h8EBB
`define CFG_ERASED_VALUE 16'hFFFF
`define RSVD_FORCE_MASK 16'h800C
`define RSVD_FORCE_VALUE 16'h8008

// ----------------------------------------------------------------------------
// Latency and wrap counts
// ----------------------------------------------------------------------------
`define LAT_BASE_CLOCKS 5'h05
`define LAT_CODE_SEQ_MAX 4'hA
`define LAT_CODE_TOP 4'hB
`define LAT_TOP_CLOCKS 5'h10
`define LAT_NONE_CLOCKS 5'h00
`define WRAP16_WORD_MASK 5'h07
`define WRAP32_WORD_MASK 5'h0F
`define WRAP64_WORD_MASK 5'h1F

`endif

/* File: pkg/bus_config_pkg.sv */
// Types of the bus configuration pair
`default_nettype none
package bus_config_pkg;

    // ------------------------------------------------------------------------
    // Field encodings and controller states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        BURST_RSVD = 2'b00,
        BURST_64 = 2'b01,
        BURST_16 = 2'b10,
        BURST_32 = 2'b11
    } burst_len_t;

    typedef enum logic [1:0] {
        MAP_PARAM_LOW = 2'b00,
        MAP_PARAM_HIGH = 2'b01,
        MAP_UNIFORM_LOW = 2'b10,
        MAP_UNIFORM_HIGH = 2'b11
    } sector_map_t;

    typedef enum logic [0:0] {
        ST_INIT = 1'b0,
        ST_RUN = 1'b1
    } ctl_state_t;

endpackage
`default_nettype wire

/* File: hw/config_lock_decode.sv */
// Lock state decode from the two freeze bits
`timescale 1ns/10ps
`default_nettype none
module config_lock_decode
(
    // Freeze bits
    input wire logic nv_freeze_i,
    input wire logic v_freeze_i,
    // Lock states
    output logic nv_alterable_o,
    output logic v_alterable_o,
    output logic permanent_o
);

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    // freeze pair decode
    always_comb
    begin
        case ({nv_freeze_i, v_freeze_i})
            2'b11:
            begin
                nv_alterable_o = 1'b1;
                v_alterable_o = 1'b1;
                permanent_o = 1'b0;
            end
            2'b10:
            begin
                nv_alterable_o = 1'b0;
                v_alterable_o = 1'b0;
                permanent_o = 1'b0;
            end
            2'b01:
            begin
                nv_alterable_o = 1'b1;
                v_alterable_o = 1'b1;
                permanent_o = 1'b0;
            end
            default:
            begin
                nv_alterable_o = 1'b0;
                v_alterable_o = 1'b0;
                permanent_o = 1'b1;
            end
        endcase
    end

endmodule // config_lock_decode
`default_nettype wire

/* File: hw/burst_address_gen.sv */
// Word address sequencer for linear and wrapped bursts
`timescale 1ns/10ps
`default_nettype none
`include "bus_config_map.svh"
module burst_address_gen
#(
    parameter int ADDR_W = 24
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Burst control
    input wire logic start_i,
    input wire logic [ADDR_W-1:0] start_addr_i,
    input wire logic linear_i,
    input wire bus_config_pkg::burst_len_t len_i,
    input wire logic next_i,
    // Current word address
    output logic [ADDR_W-1:0] addr_o
);

    logic [ADDR_W-1:0] wrap_mask;
    logic [ADDR_W-1:0] next_mask;
    logic [ADDR_W-1:0] next_addr;
    logic [ADDR_W-1:0] addr_inc;

    // ------------------------------------------------------------------------
    // Wrap group per length code
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_mask = '0;
        case (len_i)
            bus_config_pkg::BURST_16: next_mask[4:0] = `WRAP16_WORD_MASK;
            bus_config_pkg::BURST_32: next_mask[4:0] = `WRAP32_WORD_MASK;
            bus_config_pkg::BURST_64: next_mask[4:0] = `WRAP64_WORD_MASK;
            default: next_mask = '1;
        endcase
        if (linear_i)
        begin
            next_mask = '1;
        end
    end

    assign addr_inc = addr_o + {{(ADDR_W-1){1'b0}}, 1'b1};
    assign next_addr = (addr_o & ~wrap_mask) | (addr_inc & wrap_mask);

    // ------------------------------------------------------------------------
    // Address register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            addr_o <= '0;
            wrap_mask <= '1;
        end
        else if (start_i)
        begin
            addr_o <= start_addr_i;
            wrap_mask <= next_mask;
        end
        else if (next_i)
        begin
            addr_o <= next_addr;
        end
    end

    wrap_stays_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (next_i && !start_i && (wrap_mask[5:0] != 6'h3F)) |=>
        ((addr_o & ~wrap_mask) == ($past(addr_o) & ~wrap_mask)))
        else $error("wrapped burst left its group");

endmodule // burst_address_gen
`default_nettype wire

/* File: verification/host_ctl_model.sv */
// Host controller model that issues configuration commands
`timescale 1ns/10ps
`default_nettype none
module host_ctl_model
(
    // Clock
    input wire logic clk_i,
    // Commands
    output logic load_o,
    output logic prog_o,
    output logic erase_o,
    output logic [15:0] data_o
);
    initial
    begin
        load_o = 1'b0;
        prog_o = 1'b0;
        erase_o = 1'b0;
        data_o = 16'h0000;
    end

    task automatic issue(input logic [1:0] kind, input logic [15:0] d);
        @(posedge clk_i);
        load_o <= (kind == 2'd0);
        prog_o <= (kind == 2'd1);
        erase_o <= (kind == 2'd2);
        data_o <= d;
        @(posedge clk_i);
        load_o <= 1'b0;
        prog_o <= 1'b0;
        erase_o <= 1'b0;
        // Released data shows its inverse so a stale sample cannot pass
        data_o <= ~d;
    endtask
endmodule // host_ctl_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench of the bus configuration register pair
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fac = 1'b1;
    logic swr = 1'b0;
    logic sec = 1'b0;
    logic bst = 1'b0;
    logic btype = 1'b0;
    logic bnext = 1'b0;
    logic [23:0] baddr = 24'h0000;
    logic load, prog, erase, refused, vsel, nv_alt, v_alt, perm, sallow, lsup;
    logic [15:0] data, vcfg, nvcfg, nv_exp, vexp, d;
    logic [2:0] drive;
    logic [1:0] smap, blen;
    logic [4:0] lat;
    logic [23:0] addr;
    logic [31:0] seed = 32'h0000_70d0;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    host_ctl_model host (.clk_i(clk), .load_o(load), .prog_o(prog), .erase_o(erase), .data_o(data));

    bus_config_register_pair DUT (.REF_CLK_I(clk), .RST_I(rst), .FACTORY_RST_I(fac), .LOAD_VOLATILE_I(load),
        .PROGRAM_NONVOLATILE_I(prog), .ERASE_NONVOLATILE_I(erase), .CONFIG_DATA_I(data), .SW_RESET_I(swr),
        .CMD_REFUSED_O(refused), .VOLATILE_BUS_CONFIG_O(vcfg), .NONVOLATILE_BUS_CONFIG_O(nvcfg),
        .VOLATILE_SELECTED_O(vsel), .NV_ALTERABLE_O(nv_alt), .V_ALTERABLE_O(v_alt), .PERMANENT_LOCK_O(perm),
        .SECURE_PROG_REQ_I(sec), .SECURE_PROG_ALLOW_O(sallow), .DRIVE_STRENGTH_O(drive), .SECTOR_MAP_O(smap),
        .READ_LATENCY_O(lat), .LATENCY_SUPPORTED_O(lsup), .BURST_LENGTH_O(blen), .BURST_START_I(bst),
        .BURST_START_ADDR_I(baddr), .BURST_TYPE_BIT_I(btype), .BURST_NEXT_I(bnext), .BURST_ADDR_O(addr));

    function automatic logic [15:0] fix(input logic [15:0] v);
        return (v & 16'h7FF3) | 16'h8008;
    endfunction
    function automatic logic [4:0] lat_of(input logic [3:0] c);
        return (c <= 4'hA) ? 5'(c) + 5'h05 : ((c == 4'hB) ? 5'h10 : 5'h00);
    endfunction
    function automatic logic [23:0] nxt(input logic [23:0] a, input logic [1:0] c, input logic t);
        logic [23:0] m;
        m = (c == 2'b10) ? 24'h0007 : ((c == 2'b11) ? 24'h000F : 24'h001F);
        return (t || c == 2'b00) ? a + 24'h0001 : (a & ~m) | ((a + 24'h0001) & m);
    endfunction
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic load_chk(input logic [15:0] v);
        host.issue(2'd0, v);
        sec <= v[2];
        vexp = fix(v);
        #1 check("volatile", 24'(vcfg), 24'(vexp));
        check("selected", 24'(vsel), 24'h0001);
        @(posedge clk);
        #1 check("drive", 24'(drive), 24'(v[14:12]));
        check("map", 24'(smap), 24'(v[9:8]));
        check("latency", 24'(lat), 24'(lat_of(v[7:4])));
        check("supported", 24'(lsup), 24'(v[7:4] <= 4'hB));
        check("length", 24'(blen), 24'(v[1:0]));
        check("secure", 24'(sallow), 24'(v[10] && v[2]));
    endtask

    task automatic burst_chk(input logic [1:0] c, input logic t, input logic [23:0] a);
        logic [23:0] e;
        e = a;
        @(posedge clk);
        bst <= 1'b1;
        baddr <= a;
        btype <= t;
        @(posedge clk);
        bst <= 1'b0;
        bnext <= 1'b1;
        baddr <= ~a;
        #1 check("burst start", addr, e);
        repeat (33)
        begin
            e = nxt(e, c, t);
            @(posedge clk);
            #1 check("burst step", addr, e);
        end
        bnext <= 1'b0;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            bad_count++;
            complete_run();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        fac <= 1'b0;
        sec <= 1'b1;
        #1 check("reset volatile", 24'(vcfg), 24'h8EBB);
        check("reset latency", 24'(lat), 24'h0010);
        check("reset map", 24'(smap), 24'h0002);
        repeat (2) @(posedge clk);
        #1 check("alterable", 24'(v_alt), 24'h0001);
        d = 16'(rnd()) | 16'h0800;
        host.issue(2'd1, d);
        nv_exp = fix(16'h8EBB & d);
        #1 check("program", 24'(nvcfg), 24'(nv_exp));
        check("copy", 24'(vcfg), 24'(nv_exp));
        check("kept source", 24'(vsel), 24'h0000);
        $display("test copy done");
        for (int i = 0; i < 16; i++)
        begin
            load_chk((16'(rnd()) & 16'hFF0F) | 16'h0800 | (16'(i) << 4));
        end
        $display("test fields done");
        for (int c = 0; c < 4; c++)
        begin
            load_chk((16'(rnd()) & 16'hFFFC) | 16'h0800 | 16'(c));
            burst_chk(2'(c), 1'b0, 24'(rnd()));
            burst_chk(2'(c), 1'b1, 24'(rnd()));
        end
        $display("test bursts done");
        host.issue(2'd2, 16'h0000);
        d = 16'(rnd()) & 16'hF7FF;
        host.issue(2'd1, d);
        nv_exp = fix(d);
        #1 check("freeze program", 24'(nvcfg), 24'(nv_exp));
        check("volatile kept", 24'(vcfg), 24'(vexp));
        check("still alterable", 24'(nv_alt), 24'h0001);
        @(posedge clk);
        #1 check("latency kept", 24'(lat), 24'(lat_of(vexp[7:4])));
        load_chk(vexp & 16'hF7FF);
        check("locked", 24'(v_alt), 24'h0000);
        check("nv locked", 24'(nv_alt), 24'h0000);
        host.issue(2'd0, 16'hFFFF);
        #1 check("refused", 24'(refused), 24'h0001);
        check("held", 24'(vcfg), 24'(vexp));
        host.issue(2'd1, 16'h0000);
        #1 check("nv refused", 24'(refused), 24'h0001);
        check("nv held", 24'(nvcfg), 24'(nv_exp));
        @(posedge clk);
        swr <= 1'b1;
        @(posedge clk);
        swr <= 1'b0;
        #1 check("select kept", 24'(vsel), 24'h0001);
        $display("test locks done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("reload", 24'(vcfg), 24'(nv_exp));
        check("permanent", 24'(perm), 24'h0001);
        check("source", 24'(vsel), 24'h0000);
        @(posedge clk);
        #1 check("nv latency", 24'(lat), 24'(lat_of(nv_exp[7:4])));
        $display("test reset done");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
